// *** rtl/omdr_diag_regs.sv ***
`timescale 1ns/10ps
module omdr_diag_regs #(
	parameter int unsigned MEAS_W        = 16,
	parameter bit          TEMP_IS_SIGNED = 1'b1
) (
	input  wire logic               core_clk,
	input  wire logic               reset,
	input  wire omdr_pkg::omdr_meas_t meas_in,
	input  wire omdr_pkg::omdr_upd_t  meas_strobe,
	input  wire logic               tx_fault_pin,
	input  wire logic               receive_signal_lost,
	input  wire logic               link_clk,
	input  wire logic               link_req,
	input  wire omdr_pkg::omdr_req_t  link_cmd,
	output logic                    link_busy,
	output logic                    link_done,
	output logic [7:0]              link_rdata
);

	// ==========================================================
	// elaboration check
	// ==========================================================
	// the byte map holds exactly two bytes per measurement
	if (MEAS_W != 16)
	begin : g_bad_width
		$error("omdr_diag_regs serves only 16-bit measurements");
	end

	// ==========================================================
	// state types
	// ==========================================================
	// core-side state: synchronisers, live values, flags, thresholds
	typedef struct packed {
		logic                  fault_s1;
		logic                  fault_s2;
		logic                  los_s1;
		logic                  los_s2;
		logic                  req_s1;
		logic                  req_s2;
		logic                  req_last;
		logic                  ack_tg;
		logic [7:0]            rdata;
		logic [4:0][15:0]      meas;
		logic [4:0]            upd;
		logic [4:0]            seen;
		logic [7:0]            alarm;
		logic [4:0][7:0]       hold;
		logic [4:0]            hold_v;
		logic [39:0][7:0]      thr;
	} omdr_core_t;

	// link-side state: reset synchroniser, request and return path
	typedef struct packed {
		logic                  rst_s1;
		logic                  rst_s2;
		logic                  req_tg;
		omdr_pkg::omdr_req_t   cmd;
		logic                  ack_s1;
		logic                  ack_s2;
		logic                  ack_last;
		logic                  busy;
		logic                  done;
		logic [7:0]            rdata;
	} omdr_link_t;

	omdr_core_t c_q;
	omdr_core_t c_d;
	omdr_link_t l_q;
	omdr_link_t l_d;

	// ==========================================================
	// helper functions
	// ==========================================================
	// high thresholds reset to all ones, low ones to zero, so no alarm at start except one of the two signed temperature alarms, set by the sign of the sample
	function automatic logic [39:0][7:0] thr_reset();
		logic [39:0][7:0] r;
		for (int i = 0; i < 40; i++)
		begin
			r[i] = (((i >> 1) & 1) == 0) ? omdr_pkg::THR_RST_HIGH : omdr_pkg::THR_RST_LOW;
		end
		return r;
	endfunction

	// two-byte threshold word, msb at the lower address
	function automatic logic [15:0] thr_word(
		input logic [39:0][7:0] t,
		input logic [5:0]       a
	);
		return {t[a], t[6'(a + 6'd1)]};
	endfunction

	// magnitude compare, signed for temperature
	function automatic logic above(
		input logic [15:0] x,
		input logic [15:0] y,
		input logic        sgn
	);
		return sgn ? ($signed(x) > $signed(y)) : (x > y);
	endfunction

	// core state after reset
	function automatic omdr_core_t core_reset();
		omdr_core_t r;
		r        = '0;
		r.meas   = {5{omdr_pkg::RST_MEAS}};
		r.rdata  = omdr_pkg::RST_BYTE;
		r.thr    = thr_reset();
		return r;
	endfunction

	// ==========================================================
	// core domain
	// ==========================================================
	logic [4:0]  strb;
	logic [4:0][15:0] mv;
	logic        clr_upd;
	logic [2:0]  pair;
	logic [2:0]  mi;
	logic        temp_sgn;

	assign strb     = meas_strobe;
	assign mv       = meas_in;
	assign temp_sgn = TEMP_IS_SIGNED;

	// next core state: sampling, alarms, host access
	always_comb
	begin
		c_d     = c_q;
		clr_upd = 1'b0;
		pair    = 3'(l_q.cmd.addr[3:1]);
		mi      = 3'(3'd4 - pair);

		// pins from outside the clock domain pass two flops
		c_d.fault_s1 = tx_fault_pin;
		c_d.fault_s2 = c_q.fault_s1;
		c_d.los_s1   = receive_signal_lost;
		c_d.los_s2   = c_q.los_s1;
		c_d.req_s1   = l_q.req_tg;
		c_d.req_s2   = c_q.req_s1;

		// new samples replace the whole word at once
		for (int i = 0; i < 5; i++)
		begin
			if (strb[i])
			begin
				c_d.meas[i] = mv[i];
			end
		end
		c_d.seen = c_q.seen | strb;

		// alarms follow each fresh temp, vcc, bias and txp sample against its thresholds
		if (strb[omdr_pkg::MI_TEMP])
		begin
			c_d.alarm[omdr_pkg::AL_TEMP_HI] = above(mv[omdr_pkg::MI_TEMP],
				thr_word(c_q.thr, omdr_pkg::THR_TEMP_HI), temp_sgn);
			c_d.alarm[omdr_pkg::AL_TEMP_LO] = above(thr_word(c_q.thr, omdr_pkg::THR_TEMP_LO),
				mv[omdr_pkg::MI_TEMP], temp_sgn);
		end
		if (strb[omdr_pkg::MI_VCC])
		begin
			c_d.alarm[omdr_pkg::AL_VCC_HI] = above(mv[omdr_pkg::MI_VCC],
				thr_word(c_q.thr, omdr_pkg::THR_VCC_HI), 1'b0);
			c_d.alarm[omdr_pkg::AL_VCC_LO] = above(thr_word(c_q.thr, omdr_pkg::THR_VCC_LO),
				mv[omdr_pkg::MI_VCC], 1'b0);
		end
		if (strb[omdr_pkg::MI_BIAS])
		begin
			c_d.alarm[omdr_pkg::AL_BIAS_HI] = above(mv[omdr_pkg::MI_BIAS],
				thr_word(c_q.thr, omdr_pkg::THR_BIAS_HI), 1'b0);
			c_d.alarm[omdr_pkg::AL_BIAS_LO] = above(thr_word(c_q.thr, omdr_pkg::THR_BIAS_LO),
				mv[omdr_pkg::MI_BIAS], 1'b0);
		end
		if (strb[omdr_pkg::MI_TXP])
		begin
			c_d.alarm[omdr_pkg::AL_TXP_HI] = above(mv[omdr_pkg::MI_TXP],
				thr_word(c_q.thr, omdr_pkg::THR_TXP_HI), 1'b0);
			c_d.alarm[omdr_pkg::AL_TXP_LO] = above(thr_word(c_q.thr, omdr_pkg::THR_TXP_LO),
				mv[omdr_pkg::MI_TXP], 1'b0);
		end

		// host access arrives as a toggle; command fields are stable by then
		if (c_q.req_s2 != c_q.req_last)
		begin
			c_d.req_last = c_q.req_s2;
			c_d.ack_tg   = ~c_q.ack_tg;
			c_d.rdata    = omdr_pkg::RST_BYTE;
			if (l_q.cmd.we)
			begin
				// only the threshold table takes writes
				if (l_q.cmd.addr < omdr_pkg::THR_BYTES)
				begin
					c_d.thr[6'(l_q.cmd.addr)] = l_q.cmd.wdata;
				end
			end
			else if (l_q.cmd.addr < omdr_pkg::THR_BYTES)
			begin
				c_d.rdata = c_q.thr[6'(l_q.cmd.addr)];
			end
			else if (l_q.cmd.addr >= omdr_pkg::OFS_TEMP_HI && l_q.cmd.addr <= omdr_pkg::OFS_RXP_LO)
			begin
				if (!l_q.cmd.addr[0])
				begin
					// high byte read freezes its low byte for the next read
					c_d.rdata      = c_q.meas[mi][15:8];
					c_d.hold[mi]   = c_q.meas[mi][7:0];
					c_d.hold_v[mi] = 1'b1;
				end
				else
				begin
					c_d.rdata      = c_q.hold_v[mi] ? c_q.hold[mi] : c_q.meas[mi][7:0];
					c_d.hold_v[mi] = 1'b0;
				end
			end
			else
			begin
				case (l_q.cmd.addr)
					omdr_pkg::OFS_STATUS:
					begin
						c_d.rdata[omdr_pkg::ST_FAULT] = c_q.fault_s2;
						c_d.rdata[omdr_pkg::ST_LOS]   = c_q.los_s2;
						c_d.rdata[omdr_pkg::ST_READY] = &c_q.seen;
					end
					omdr_pkg::OFS_UPDATE:
					begin
						c_d.rdata = {c_q.upd, 3'h0};
						clr_upd   = 1'b1;
					end
					omdr_pkg::OFS_ALARM:
					begin
						c_d.rdata = c_q.alarm;
					end
					default:
					begin
						c_d.rdata = omdr_pkg::RST_BYTE;
					end
				endcase
			end
		end

		// update flags: a new sample wins over the clear by read
		c_d.upd = (c_q.upd & ~{5{clr_upd}}) | strb;
	end

	// core state register
	always_ff @(posedge core_clk)
	begin
		if (reset)
		begin
			c_q <= core_reset();
		end
		else
		begin
			c_q <= c_d;
		end
	end

	// ==========================================================
	// link domain
	// ==========================================================
	// next link state: take one access, wait for the core's answer
	always_comb
	begin
		l_d        = l_q;
		l_d.rst_s1 = reset;
		l_d.rst_s2 = l_q.rst_s1;
		l_d.ack_s1 = c_q.ack_tg;
		l_d.ack_s2 = l_q.ack_s1;
		l_d.done   = 1'b0;

		if (l_q.busy && (l_q.ack_s2 != l_q.ack_last))
		begin
			// core data is stable once its toggle has been seen
			l_d.ack_last = l_q.ack_s2;
			l_d.busy     = 1'b0;
			l_d.done     = 1'b1;
			l_d.rdata    = c_q.rdata;
		end
		else if (!l_q.busy && link_req)
		begin
			// requests while busy are dropped
			l_d.cmd    = link_cmd;
			l_d.req_tg = ~l_q.req_tg;
			l_d.busy   = 1'b1;
		end

		// reset held over from the core domain
		if (l_q.rst_s2)
		begin
			l_d.req_tg   = 1'b0;
			l_d.ack_last = 1'b0;
			l_d.busy     = 1'b0;
			l_d.done     = 1'b0;
			l_d.cmd      = '0;
			l_d.rdata    = omdr_pkg::RST_BYTE;
		end
	end

	// link state register
	always_ff @(posedge link_clk)
	begin
		l_q <= l_d;
	end

	// ==========================================================
	// outputs
	// ==========================================================
	assign link_busy  = l_q.busy | l_q.rst_s2;
	assign link_done  = l_q.done;
	assign link_rdata = l_q.rdata;

endmodule

// *** rtl/omdr_pkg.sv ***
package omdr_pkg;

	// ==========================================================
	// measurement carriers
	// ==========================================================
	// five live measurements, first field is the highest slice
	typedef struct packed {
		logic [15:0] temp;
		logic [15:0] vcc;
		logic [15:0] bias;
		logic [15:0] txp;
		logic [15:0] rxp;
	} omdr_meas_t;

	// one new-sample strobe per measurement, same field order
	typedef struct packed {
		logic temp;
		logic vcc;
		logic bias;
		logic txp;
		logic rxp;
	} omdr_upd_t;

	// host access captured at the link side
	typedef struct packed {
		logic       we;
		logic [7:0] addr;
		logic [7:0] wdata;
	} omdr_req_t;

	// ==========================================================
	// measurement slice indices
	// ==========================================================
	localparam int unsigned MEAS_N  = 5;
	localparam int unsigned MI_TEMP = 4;
	localparam int unsigned MI_VCC  = 3;
	localparam int unsigned MI_BIAS = 2;
	localparam int unsigned MI_TXP  = 1;
	localparam int unsigned MI_RXP  = 0;

	// ==========================================================
	// register offsets in the diagnostic block
	// ==========================================================
	localparam logic [7:0] OFS_TEMP_HI   = 8'h60;
	localparam logic [7:0] OFS_TEMP_LO   = 8'h61;
	localparam logic [7:0] OFS_VCC_HI    = 8'h62;
	localparam logic [7:0] OFS_VCC_LO    = 8'h63;
	localparam logic [7:0] OFS_BIAS_HI   = 8'h64;
	localparam logic [7:0] OFS_BIAS_LO   = 8'h65;
	localparam logic [7:0] OFS_TXP_HI    = 8'h66;
	localparam logic [7:0] OFS_TXP_LO    = 8'h67;
	localparam logic [7:0] OFS_RXP_HI    = 8'h68;
	localparam logic [7:0] OFS_RXP_LO    = 8'h69;
	localparam logic [7:0] OFS_STATUS    = 8'h6e;
	localparam logic [7:0] OFS_UPDATE    = 8'h6f;
	localparam logic [7:0] OFS_ALARM     = 8'h70;

	// ==========================================================
	// threshold table, msb at the lower address
	// ==========================================================
	localparam logic [7:0] THR_BYTES     = 8'h28;
	localparam logic [5:0] THR_TEMP_HI   = 6'h00;
	localparam logic [5:0] THR_TEMP_LO   = 6'h02;
	localparam logic [5:0] THR_VCC_HI    = 6'h08;
	localparam logic [5:0] THR_VCC_LO    = 6'h0a;
	localparam logic [5:0] THR_BIAS_HI   = 6'h10;
	localparam logic [5:0] THR_BIAS_LO   = 6'h12;
	localparam logic [5:0] THR_TXP_HI    = 6'h18;
	localparam logic [5:0] THR_TXP_LO    = 6'h1a;
	localparam logic [7:0] THR_RST_HIGH  = 8'hff;
	localparam logic [7:0] THR_RST_LOW   = 8'h00;

	// ==========================================================
	// bit positions
	// ==========================================================
	localparam int unsigned ST_FAULT     = 2;
	localparam int unsigned ST_LOS       = 1;
	localparam int unsigned ST_READY     = 0;
	localparam int unsigned UPD_LSB      = 3;
	localparam int unsigned AL_TEMP_HI   = 7;
	localparam int unsigned AL_TEMP_LO   = 6;
	localparam int unsigned AL_VCC_HI    = 5;
	localparam int unsigned AL_VCC_LO    = 4;
	localparam int unsigned AL_BIAS_HI   = 3;
	localparam int unsigned AL_BIAS_LO   = 2;
	localparam int unsigned AL_TXP_HI    = 1;
	localparam int unsigned AL_TXP_LO    = 0;

	// ==========================================================
	// reset values
	// ==========================================================
	localparam logic [7:0]  RST_BYTE     = 8'h00;
	localparam logic [15:0] RST_MEAS     = 16'h0000;

endpackage

// *** tb/omdr_diag_sva.sv ***
`timescale 1ns/10ps
// ==========================================================
// access port checker, link domain
// ==========================================================
module omdr_diag_sva (
	input wire logic       link_clk,
	input wire logic       reset,
	input wire logic       link_req,
	input wire logic       link_busy,
	input wire logic       link_done,
	input wire logic [7:0] link_rdata
);
	default clocking @(posedge link_clk); endclocking
	default disable iff (reset);

	// completion handshake
	a_done_one_pulse: assert property (link_done |=> !link_done)
		else $error("done wider than one cycle");
	a_take_sets_busy: assert property (link_req && !link_busy |=> link_busy [*2])
		else $error("busy not held after take");
	a_done_in_time: assert property (link_req && !link_busy |-> ##[3:6] link_done)
		else $error("access not answered in time");
	a_done_frees_port: assert property (link_done |-> !link_busy)
		else $error("busy still high at done");
	a_done_needs_busy: assert property (link_done |-> $past(link_busy))
		else $error("done without access in flight");
	a_rdata_on_done: assert property ($changed(link_rdata) |-> link_done)
		else $error("read data moved outside done");
	a_idle_no_done: assert property (!link_busy && !link_req |=> !link_done)
		else $error("done while idle");
	a_reset_quiet: assert property (disable iff (1'b0) reset [*5] |-> link_busy && !link_done && link_rdata == 8'h00)
		else $error("port not quiet in reset");
endmodule

bind omdr_diag_regs omdr_diag_sva u_sva (.link_clk(link_clk), .reset(reset), .link_req(link_req),
	.link_busy(link_busy), .link_done(link_done), .link_rdata(link_rdata));

// *** tb/omdr_host_model.sv ***
`timescale 1ns/10ps
// ==========================================================
// host side of the access port
// ==========================================================
module omdr_host_model (
	input  wire logic           link_clk,
	input  wire logic           link_busy,
	input  wire logic           link_done,
	output logic                link_req,
	output omdr_pkg::omdr_req_t link_cmd
);
	// idle port at time zero
	initial
	begin
		link_req = 1'b0;
		link_cmd = '0;
	end

	// one access: wait for a free port, hold request to the taking edge, await done
	task automatic xfer(input logic we, input logic [7:0] a, input logic [7:0] d);
		int n;
	begin
		n = 0;
		@(posedge link_clk);
		while (link_busy !== 1'b0)
			@(posedge link_clk);
		link_req <= 1'b1;
		link_cmd <= {we, a, d};
		@(posedge link_clk);
		link_req <= 1'b0;
		link_cmd <= omdr_pkg::omdr_req_t'(~link_cmd); // released bus shows no stale value
		while (link_done !== 1'b1 && n < 10)
		begin
			@(posedge link_clk);
			n++;
		end
	end
	endtask
endmodule

// *** tb/tb_top.sv ***
`timescale 1ns/10ps
module tb_top;
	logic                 core_clk    = 1'b0;
	logic                 link_clk    = 1'b0;
	logic                 reset       = 1'b1;
	omdr_pkg::omdr_meas_t meas_in     = '0;
	omdr_pkg::omdr_meas_t mdl         = '0;
	omdr_pkg::omdr_upd_t  meas_strobe = '0;
	logic                 tx_fault    = 1'b0;
	logic                 sig_lost    = 1'b0;
	logic                 link_req;
	omdr_pkg::omdr_req_t  link_cmd;
	logic                 link_busy;
	logic                 link_done;
	logic [7:0]           link_rdata;
	logic [8:0]           exp_q[$];
	logic [8:0]           e;
	logic [15:0]          v;
	logic [15:0]          tbl[5]      = '{16'h4001, 16'h4000, 16'h0fff, 16'h1000, 16'h8000};
	int                   err_total   = 0;
	int                   n_tests     = 0;
	int                   seed        = 44696;
	int                   cyc         = 0;

	// ==========================================================
	// clocks and instances
	// ==========================================================
	always #2.5 core_clk = ~core_clk;
	always #24 link_clk = ~link_clk;

	omdr_diag_regs u_dut (.core_clk(core_clk), .reset(reset), .meas_in(meas_in), .meas_strobe(meas_strobe),
		.tx_fault_pin(tx_fault), .receive_signal_lost(sig_lost), .link_clk(link_clk), .link_req(link_req),
		.link_cmd(link_cmd), .link_busy(link_busy), .link_done(link_done), .link_rdata(link_rdata));
	omdr_host_model u_host (.link_clk(link_clk), .link_busy(link_busy), .link_done(link_done),
		.link_req(link_req), .link_cmd(link_cmd));

	// ==========================================================
	// tasks
	// ==========================================================
	task automatic rd(input logic [7:0] a, input logic [7:0] x);
	begin
		exp_q.push_back({1'b1, x});
		u_host.xfer(1'b0, a, 8'h00);
	end
	endtask

	task automatic wr(input logic [7:0] a, input logic [7:0] d);
	begin
		exp_q.push_back(9'h000);
		u_host.xfer(1'b1, a, d);
	end
	endtask

	// present the model values with a one-cycle strobe
	task automatic smp(input logic [4:0] s);
	begin
		@(posedge core_clk);
		meas_in     <= mdl;
		meas_strobe <= s;
		@(posedge core_clk);
		meas_strobe <= '0;
		repeat (3) @(posedge core_clk);
	end
	endtask

	// expected alarm byte, thresholds 4000 high and 1000 low, temperature signed
	function automatic logic [7:0] alm(input omdr_pkg::omdr_meas_t m);
		logic [63:0] w;
		logic [15:0] x;
		alm = 8'h00;
		w = m[79:16];
		for (int i = 0; i < 4; i++)
		begin
			x = w[63-16*i -: 16];
			if (i == 0)
			begin
				alm[7] = $signed(x) > $signed(16'h4000);
				alm[6] = $signed(x) < $signed(16'h1000);
			end
			else
			begin
				alm[7-2*i] = x > 16'h4000;
				alm[6-2*i] = x < 16'h1000;
			end
		end
	endfunction

	task automatic final_report;
	begin
		if (err_total == 0 && n_tests > 0)
			$display("Result: passed");
		else
			$display("Result: failed");
		$finish;
	end
	endtask

	// ==========================================================
	// result monitor and timeout
	// ==========================================================
	// sampled mid-cycle, where done and read data have settled
	always @(negedge link_clk)
		if (link_done === 1'b1 && exp_q.size() == 0)
		begin
			err_total++;
			$display("mismatch t=%0t got %h exp %h", $time, link_rdata, 8'h00);
		end
		else if (link_done === 1'b1)
		begin
			e = exp_q.pop_front();
			if (e[8])
				n_tests++;
			if (e[8] && link_rdata !== e[7:0])
			begin
				err_total++;
				$display("mismatch t=%0t got %h exp %h", $time, link_rdata, e[7:0]);
			end
		end

	always @(posedge core_clk)
	begin
		cyc++;
		if (cyc == 60000)
		begin
			err_total++;
			final_report;
		end
	end

	// ==========================================================
	// main sequence
	// ==========================================================
	initial
	begin
		repeat (60) @(posedge core_clk);
		reset <= 1'b0;
		repeat (60) @(posedge core_clk);
		rd(8'h6e, 8'h00);
		rd(8'h6f, 8'h00);
		for (int i = 0; i < 5; i++)
			mdl[i*16 +: 16] = 16'($random(seed));
		smp(5'h1f);
		for (int i = 0; i < 5; i++)
		begin
			rd(8'h60 + 8'(2*i), mdl[(4-i)*16+8 +: 8]);
			rd(8'h61 + 8'(2*i), mdl[(4-i)*16 +: 8]);
		end
		// low byte stays with its high byte across a new sample
		rd(8'h60, mdl.temp[15:8]);
		v = mdl.temp;
		mdl.temp = ~v;
		smp(5'h10);
		rd(8'h61, v[7:0]);
		rd(8'h61, mdl.temp[7:0]);
		rd(8'h6f, 8'hf8);
		rd(8'h6f, 8'h00);
		for (int i = 0; i < 5; i++)
		begin
			smp(5'h01 << i);
			rd(8'h6f, 8'h08 << i);
		end
		// every fault and signal-lost combination, ready already set
		for (int i = 0; i < 4; i++)
		begin
			@(posedge core_clk);
			{tx_fault, sig_lost} <= 2'(i);
			repeat (6) @(posedge core_clk);
			rd(8'h6e, {5'h00, 2'(i), 1'b1});
		end
		for (int i = 0; i < 4; i++)
		begin
			wr(8'(8*i), 8'h40);
			wr(8'(8*i+1), 8'h00);
			wr(8'(8*i+2), 8'h10);
			wr(8'(8*i+3), 8'h00);
		end
		rd(8'h08, 8'h40);
		// boundary values first, then random ones
		for (int k = 0; k < 9; k++)
		begin
			for (int i = 0; i < 5; i++)
				mdl[i*16 +: 16] = (k < 5) ? tbl[k] : 16'($random(seed)) & 16'h7fff;
			smp(5'h1f);
			rd(8'h70, alm(mdl));
		end
		wr(8'h60, ~mdl.temp[15:8]);
		wr(8'h70, 8'hff);
		rd(8'h60, mdl.temp[15:8]);
		rd(8'h70, alm(mdl));
		rd(8'h6a, 8'h00);
		repeat (3) @(posedge link_clk);
		// an access that never completed leaves its note behind
		if (exp_q.size() != 0)
			err_total++;
		final_report;
	end
endmodule
